//--- sai_pkg.sv
// Shared constants, state encodings and carrier structs for the serial converter interface
package sai_pkg;

  // ******************************************************
  // Resolution variants and word layout
  // ******************************************************
  localparam int unsigned RES_12     = 12;
  localparam int unsigned RES_10     = 10;
  localparam int unsigned RES_8      = 8;
  localparam int unsigned CODE_W     = 12;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0]  LEAD_ZEROS = 4'h0;

  // ******************************************************
  // Edge counts, all referenced to the select falling edge
  // ******************************************************
  localparam logic [4:0] CNT_STEP    = 5'h01;
  localparam logic [4:0] CNT_ZERO    = 5'h00;
  localparam logic [4:0] FALLS_NOISE = 5'h02;
  localparam logic [4:0] FALLS_KEEP  = 5'h0A;
  localparam logic [4:0] RISE_TRACK  = 5'h0D;
  localparam logic [4:0] FALLS_WORD  = 5'h10;

  // Synchroniser reset values: select idles high, serial clock low
  localparam logic [2:0] SYNC_HIGH = 3'h7;
  localparam logic [2:0] SYNC_LOW  = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } sai_state_t;

  typedef struct packed {
    logic [2:0]        cs_s;
    logic [2:0]        sck_s;
    sai_state_t        st;
    logic [4:0]        falls;
    logic [4:0]        rises;
    logic [WORD_W-1:0] shreg;
    logic [CODE_W-1:0] samp;
    logic              sd;
    logic              oe_b;
    logic              hold;
    logic              normal;
    logic              powered;
    logic              wake;
    logic              dummy;
  } sai_core_t;

  localparam sai_core_t CORE_RST = '{
    cs_s:    SYNC_HIGH,
    sck_s:   SYNC_LOW,
    st:      ST_IDLE,
    falls:   CNT_ZERO,
    rises:   CNT_ZERO,
    shreg:   16'h0000,
    samp:    12'h000,
    sd:      1'b0,
    oe_b:    1'b1,
    hold:    1'b0,
    normal:  1'b0,
    powered: 1'b0,
    wake:    1'b0,
    dummy:   1'b0
  };

endpackage

//--- sai_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sai_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rst_b,     // Synchronous reset, active low
  input  wire logic             in_valid,  // Writer offers a word
  input  wire logic [WIDTH-1:0] in_data,   // Word offered
  output logic                  in_ready,  // Room for a word, registered
  output logic                  out_valid, // Head word present
  output logic      [WIDTH-1:0] out_data,  // Head word
  input  wire logic             out_ready  // Reader takes the head word
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } sai_fifo_st_t;

  sai_fifo_st_t q;
  sai_fifo_st_t d;
  logic         push;
  logic         pop;

  assign push      = in_valid & q.rdy;
  assign pop       = out_ready & out_valid;
  assign in_ready  = q.rdy;
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = q.rd + AW'(1);
    end
    unique case ({push, pop})
      2'b10:   d.cnt = q.cnt + (AW+1)'(1);
      2'b01:   d.cnt = q.cnt - (AW+1)'(1);
      default: d.cnt = q.cnt;
    endcase
    // Ready only while a slot is free, so the writer really stalls
    d.rdy = (d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // sai_fifo

//--- sai_core.sv
// Conversion control and serial result shifter of the converter interface
// Operation
// [RULE1] Select fall samples input, starts conversion, enables serial output.
// [RULE2] Return to track on 13th rising clock edge after select fall.
// [RULE3] Output floats after 16th falling edge or on select rise.
// [RULE4] Host waits the quiet time before lowering select again.
// [RULE5] Sixteen clock cycles per sample; bits shift out on falling edges.
// [RULE6] Word starts with four zeros, then result bits, MSB first.
// [RULE7] 10-bit variant appends two zeros, 8-bit four, 12-bit none.
// [RULE8] Leading zero presented at select fall; valid if first edge rises.
// [RULE9] Result is straight binary code of the selected resolution.
// [RULE10] Edge counts restart at every select falling edge.
// [RULE11] Two modes; select low enters normal mode and starts conversion.
// [RULE12] Select rising before tenth falling edge enters shutdown.
// [RULE13] Host holds select low past 10th fall to stay normal.
// [RULE14] Select rising between 10th and 16th fall aborts, stays normal.
// [RULE15] After sixteen cycles select must rise before next conversion.
// [RULE16] Select low in shutdown powers up; first conversion is a dummy.
// [RULE17] Select rising before second falling edge leaves mode unchanged.
// [RULE18] Leaving shutdown held past tenth fall: powered after 16 cycles.
// [RULE19] While select is high, clock edges are ignored, output floats.
`timescale 1ns/1ps
module sai_core #(
  parameter int unsigned RES_BITS = sai_pkg::RES_12
) (
  input  wire logic                      CLK,                // 40 MHz system clock
  input  wire logic                      RST_B,              // Synchronous reset, active low
  input  wire logic                      CS_B,               // Select pin, active low
  input  wire logic                      SCLK,               // Serial clock pin from host
  input  wire logic                      SAMPLE_VALID,       // Converter core offers a code
  input  wire logic [sai_pkg::CODE_W-1:0] SAMPLE_CODE,       // Straight binary code
  output logic                           SAMPLE_READY,       // Sample buffer has room
  output logic                           SERIAL_RESULT_OUT,  // Serial result data
  output logic                           SERIAL_RESULT_OE_B, // Output enable, low drives pin
  output logic                           HOLD,               // High in hold, low in track
  output logic                           NORMAL_MODE,        // High normal, low shutdown
  output logic                           POWERED,            // Fully powered up
  output logic                           DUMMY_CONV          // Current conversion unusable
);

  // ******************************************************
  // Word layout per variant
  // ******************************************************
  function automatic logic [sai_pkg::WORD_W-1:0] build_word(
    input logic [sai_pkg::CODE_W-1:0] code
  );
    logic [sai_pkg::WORD_W-1:0] w;
    w = {sai_pkg::LEAD_ZEROS, code};
    if (RES_BITS == sai_pkg::RES_10) begin
      w = {sai_pkg::LEAD_ZEROS, code[9:0], 2'h0};
    end else if (RES_BITS == sai_pkg::RES_8) begin
      w = {sai_pkg::LEAD_ZEROS, code[7:0], 4'h0};
    end
    return w;
  endfunction

  sai_pkg::sai_core_t         q;
  sai_pkg::sai_core_t         d;
  logic                       cs_fall;
  logic                       cs_rise;
  logic                       sck_rise;
  logic                       sck_fall;
  logic                       head_valid;
  logic [sai_pkg::CODE_W-1:0] head_code;
  logic                       head_pop;
  logic [sai_pkg::CODE_W-1:0] code_now;
  logic [sai_pkg::WORD_W-1:0] word_now;
  logic                       next_bit;

  // ******************************************************
  // Sample buffer between converter core and shifter
  // ******************************************************
  sai_fifo #(
    .WIDTH (sai_pkg::CODE_W),
    .DEPTH (sai_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_b     (RST_B),
    .in_valid  (SAMPLE_VALID),
    .in_data   (SAMPLE_CODE),
    .in_ready  (SAMPLE_READY),
    .out_valid (head_valid),
    .out_data  (head_code),
    .out_ready (head_pop)
  );

  // Edges seen only on the second and third synchroniser stages
  assign cs_fall  = q.cs_s[2] & ~q.cs_s[1];
  assign cs_rise  = ~q.cs_s[2] & q.cs_s[1];
  assign sck_rise = ~q.sck_s[2] & q.sck_s[1];
  assign sck_fall = q.sck_s[2] & ~q.sck_s[1];
  assign next_bit = q.shreg[sai_pkg::WORD_W-2];

  // An empty buffer repeats the last held code rather than stalling the host
  assign code_now = head_valid ? head_code : q.samp;
  assign word_now = build_word(code_now);
  assign head_pop = (q.st == sai_pkg::ST_IDLE) & cs_fall & head_valid;

  // ******************************************************
  // Next-state logic
  // ******************************************************
  always_comb begin
    d       = q;
    d.cs_s  = {q.cs_s[1:0], CS_B};
    d.sck_s = {q.sck_s[1:0], SCLK};
    unique case (q.st)
      sai_pkg::ST_IDLE: begin
        // [RULE19] Idle ignores clock
        if (cs_fall) begin
          d.st     = sai_pkg::ST_CONV;
          // [RULE10] Restart edge counts
          d.falls  = sai_pkg::CNT_ZERO;
          d.rises  = sai_pkg::CNT_ZERO;
          // [RULE1] Sample and drive
          d.samp   = code_now;
          d.hold   = 1'b1;
          d.oe_b   = 1'b0;
          // [RULE9] Binary code, variant layout
          d.shreg  = word_now;
          // [RULE8] First zero set up now
          d.sd     = word_now[sai_pkg::WORD_W-1];
          // [RULE11] Select low enters normal
          d.normal = 1'b1;
          // [RULE16] Wake from shutdown is dummy
          d.wake   = ~q.normal;
          d.dummy  = ~q.normal | ~q.powered;
        end
      end
      sai_pkg::ST_CONV: begin
        if (cs_rise) begin
          // [RULE3] Select rise floats output
          d.st   = sai_pkg::ST_IDLE;
          d.oe_b = 1'b1;
          d.hold = 1'b0;
          if (q.wake) begin
            // [RULE16] Early rise during wake returns to shutdown
            if (q.falls < sai_pkg::FALLS_KEEP) begin
              d.normal  = 1'b0;
              d.powered = 1'b0;
            end
          end else if (q.falls >= sai_pkg::FALLS_NOISE &&
                       q.falls < sai_pkg::FALLS_KEEP) begin
            // [RULE12] Enter shutdown
            d.normal  = 1'b0;
            d.powered = 1'b0;
          end
          // [RULE17] Below two falls mode is kept
          // [RULE14] Late rise aborts, mode stays normal
        end else begin
          if (sck_rise) begin
            d.rises = q.rises + sai_pkg::CNT_STEP;
            // [RULE2] Back to track
            if (d.rises == sai_pkg::RISE_TRACK) begin
              d.hold = 1'b0;
            end
          end
          if (sck_fall) begin
            d.falls = q.falls + sai_pkg::CNT_STEP;
            if (d.falls == sai_pkg::FALLS_WORD) begin
              // [RULE3] Float after 16th fall
              d.st   = sai_pkg::ST_DONE;
              d.oe_b = 1'b1;
              // [RULE18] Powered after 16 cycles
              if (q.wake) begin
                d.powered = 1'b1;
              end
            end else begin
              // [RULE5] Shift on falling edge
              // [RULE6] Zeros then result, MSB first
              // [RULE7] Trailing zeros per variant
              d.shreg = {q.shreg[sai_pkg::WORD_W-2:0], 1'b0};
              d.sd    = next_bit;
            end
          end
        end
      end
      sai_pkg::ST_DONE: begin
        // [RULE15] Select must rise before next start
        if (cs_rise) begin
          d.st   = sai_pkg::ST_IDLE;
          d.hold = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      q <= sai_pkg::CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign SERIAL_RESULT_OUT  = q.sd;
  assign SERIAL_RESULT_OE_B = q.oe_b;
  assign HOLD               = q.hold;
  assign NORMAL_MODE        = q.normal;
  assign POWERED            = q.powered;
  assign DUMMY_CONV         = q.dummy;

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  logic start_ev;
  assign start_ev = (q.st == sai_pkg::ST_IDLE) & cs_fall;

  a_start_drive_hold: assert property ( // [RULE1]
    start_ev |=> !SERIAL_RESULT_OE_B && HOLD)
    else $error("select fall did not drive output and hold");

  a_track_thirteen: assert property ( // [RULE2]
    (q.st == sai_pkg::ST_CONV) && !cs_rise && sck_rise && (q.rises == 5'h0C)
      |=> !HOLD)
    else $error("hold not released on 13th rising edge");

  a_float_sixteen: assert property ( // [RULE3]
    (q.st == sai_pkg::ST_CONV) && !cs_rise && sck_fall && (q.falls == 5'h0F)
      |=> SERIAL_RESULT_OE_B && (q.st == sai_pkg::ST_DONE))
    else $error("output not floated after 16th fall");

  a_float_on_rise: assert property ( // [RULE3]
    (q.st == sai_pkg::ST_CONV) && cs_rise |=> SERIAL_RESULT_OE_B && !HOLD)
    else $error("output not floated on select rise");

  a_shift_on_fall: assert property ( // [RULE5]
    (q.st == sai_pkg::ST_CONV) && !cs_rise && sck_fall && (q.falls < 5'h0F)
      |=> SERIAL_RESULT_OUT == $past(next_bit))
    else $error("bit not shifted on falling edge");

  a_lead_zeros: assert property ( // [RULE6]
    start_ev |=> !SERIAL_RESULT_OUT && (q.shreg[15:12] == 4'h0))
    else $error("word does not start with four zeros");

  a_shutdown_entry: assert property ( // [RULE12]
    (q.st == sai_pkg::ST_CONV) && cs_rise && !q.wake &&
      (q.falls >= 5'h02) && (q.falls < 5'h0A) |=> !NORMAL_MODE && !POWERED)
    else $error("shutdown not entered");

  a_noise_keep: assert property ( // [RULE17]
    (q.st == sai_pkg::ST_CONV) && cs_rise && !q.wake && (q.falls < 5'h02)
      |=> NORMAL_MODE)
    else $error("mode changed on early select rise");

  a_abort_normal: assert property ( // [RULE14]
    (q.st == sai_pkg::ST_CONV) && cs_rise && (q.falls >= 5'h0A)
      |=> NORMAL_MODE && SERIAL_RESULT_OE_B)
    else $error("late rise did not abort in normal mode");

  a_wake_dummy: assert property ( // [RULE16]
    start_ev && !NORMAL_MODE |=> NORMAL_MODE && DUMMY_CONV)
    else $error("wake conversion not marked dummy");

  a_powered_after: assert property ( // [RULE18]
    (q.st == sai_pkg::ST_CONV) && q.wake && !cs_rise && sck_fall &&
      (q.falls == 5'h0F) |=> POWERED)
    else $error("not powered after 16 cycles");

  a_idle_float: assert property ( // [RULE19]
    (q.st == sai_pkg::ST_IDLE) |-> SERIAL_RESULT_OE_B)
    else $error("output driven while idle");

  // Padding positions in detected falls; the 12-bit variant never reaches TRAIL_FROM
  localparam logic [4:0] LEAD_N     = 5'($bits(sai_pkg::LEAD_ZEROS));
  localparam logic [4:0] TRAIL_FROM = 5'(sai_pkg::WORD_W - (sai_pkg::CODE_W - RES_BITS));

  a_count_restart: assert property ( // [RULE10]
    start_ev |=> (q.falls == sai_pkg::CNT_ZERO) && (q.rises == sai_pkg::CNT_ZERO))
    else $error("edge counts not restarted at select fall");

  a_normal_on_start: assert property ( // [RULE11]
    start_ev |=> NORMAL_MODE)
    else $error("select fall did not enter normal mode");

  a_lead_zero_bits: assert property ( // [RULE6]
    (q.st == sai_pkg::ST_CONV) && (q.falls < LEAD_N) |-> !SERIAL_RESULT_OUT)
    else $error("leading zero not on output");

  a_trail_zero_bits: assert property ( // [RULE7]
    (q.st == sai_pkg::ST_CONV) && (q.falls >= TRAIL_FROM) |-> !SERIAL_RESULT_OUT)
    else $error("trailing zero not on output");

  a_wake_abandon: assert property ( // [RULE16]
    (q.st == sai_pkg::ST_CONV) && cs_rise && q.wake &&
      (q.falls < sai_pkg::FALLS_KEEP) |=> !NORMAL_MODE && !POWERED)
    else $error("early rise during wake did not return to shutdown");

  a_valid_after_wake: assert property ( // [RULE16]
    start_ev && NORMAL_MODE && POWERED |=> !DUMMY_CONV)
    else $error("conversion after power-up marked unusable");

  a_done_wait: assert property ( // [RULE15]
    (q.st == sai_pkg::ST_DONE) && !cs_rise
      |=> (q.st == sai_pkg::ST_DONE) && SERIAL_RESULT_OE_B)
    else $error("left finished word without select rise");

  a_idle_no_count: assert property ( // [RULE19]
    (q.st == sai_pkg::ST_IDLE) && !cs_fall |=> $stable(q.falls) && $stable(q.shreg))
    else $error("clock edge counted while idle");

endmodule // sai_core

//--- sai_host.sv
// Host serial port model: frames select, drives the serial clock, captures result words
`timescale 1ns/1ps
module sai_host #(
  parameter int QUIET_NS = 300  // Select-high gap kept after every conversion
) (
  output logic            cs_b,  // Select, active low
  output logic            sclk,  // Serial clock, also toggled by idle_clocks after a word with select still low, or with select high
  input  wire logic [2:0] sd,    // Resolved result line of each variant
  input  wire logic [2:0] hold   // Hold flag of each variant, recorded per fall
);
  // 200 ns serial clock period
  localparam int HALF_NS = 100;
  logic [2:0][15:0] word;
  logic [2:0][15:0] hold_w;

  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
  end

  // ******************************************************
  // Frame control
  // ******************************************************
  // capture on falls
  task automatic start(input int falls, input bit fall_first);
    word   = '0;
    hold_w = '0;
    sclk   = fall_first;
    #(HALF_NS);
    cs_b = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < 2 * falls; i++) begin
      sclk = ~sclk;
      if (!sclk) begin
        for (int l = 0; l < 3; l++) begin
          word[l]   = {word[l][14:0], sd[l]};
          hold_w[l] = {hold_w[l][14:0], hold[l]};
        end
      end
      #(HALF_NS);
    end
  endtask

  task automatic finish();
    cs_b = 1'b1;
    #(QUIET_NS);
  endtask

  // Even count, so the clock ends at the level it started from
  task automatic idle_clocks(input int n);
    repeat (2 * n) begin
      #(HALF_NS);
      sclk = ~sclk;
    end
  endtask
endmodule // sai_host

//--- serial_sar_adc_interface_bench.sv
// Self-checking bench: three resolution variants share one host model and one sample source
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module serial_sar_adc_interface_bench;
  localparam int unsigned RES [3] = '{sai_pkg::RES_12, sai_pkg::RES_10, sai_pkg::RES_8};
  localparam int DLY = 2;
  logic                       clk;
  logic                       rst_b;
  logic                       valid;
  logic [sai_pkg::CODE_W-1:0] code;
  logic [sai_pkg::CODE_W-1:0] last;
  logic [sai_pkg::CODE_W-1:0] q [$];
  logic [2:0]                 rdy, sout, oe_b, hold, nm, pw, dm;
  wire  [2:0]                 sd;
  wire                        cs_b;
  wire                        sclk;
  int                         bad_count = 0;
  int                         total_checks = 0;

  // ******************************************************
  // Devices and host
  // ******************************************************
  for (genvar i = 0; i < 3; i++) begin : g_var
    assign sd[i] = oe_b[i] ? 1'bz : sout[i];
    sai_core #(.RES_BITS(RES[i])) uut (
      .CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .SAMPLE_VALID(valid),
      .SAMPLE_CODE(code), .SAMPLE_READY(rdy[i]), .SERIAL_RESULT_OUT(sout[i]),
      .SERIAL_RESULT_OE_B(oe_b[i]), .HOLD(hold[i]), .NORMAL_MODE(nm[i]),
      .POWERED(pw[i]), .DUMMY_CONV(dm[i]));
  end

  sai_host host (.cs_b(cs_b), .sclk(sclk), .sd(sd), .hold(hold));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ******************************************************
  // Helpers and scenarios
  // ******************************************************
  function automatic logic [15:0] exp_word(input int unsigned res, input logic [11:0] c);
    return ({4'h0, c} & ((16'h1 << res) - 16'h1)) << (12 - res);
  endfunction

  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Same lag as every other input; host edges then stay whole clock periods apart
  task automatic begin_frame(input int falls, input bit ff);
    @(posedge clk);
    #DLY;
    if (q.size() > 0) last = q.pop_front();
    host.start(falls, ff);
  endtask

  task automatic chk_word(input int n, input logic [15:0] msk);
    for (int i = 0; i < 3; i++)
      `CHK(host.word[i] & msk, (exp_word(RES[i], last) >> (16 - n)) & msk)
  endtask

  task automatic t_reset();
    `CHK({oe_b, nm, pw, hold, dm, rdy}, 18'h38007)
  endtask

  task automatic t_fill();
    for (int n = 0; n < sai_pkg::FIFO_DEPTH; n++) begin
      `CHK(rdy, 3'h7)
      code  = 12'(n * 12'h111);
      valid = 1'b1;
      q.push_back(code);
      @(posedge clk);
      #DLY;
    end
    valid = 1'b0;
    @(posedge clk);
    #DLY;
    `CHK(rdy, 3'h0)
    code  = 12'h5A5;
    valid = 1'b1;
    repeat (3) @(posedge clk);
    #DLY;
    valid = 1'b0;
  endtask

  task automatic t_wake();
    begin_frame(16, 1'b0);
    `CHK({nm, dm, pw, oe_b}, 12'hFFF)
    chk_word(16, 16'hFFFF);
    host.finish();
    `CHK(rdy, 3'h7)
  endtask

  task automatic t_full();
    begin_frame(16, 1'b0);
    `CHK({nm, dm, oe_b}, 9'h1C7)
    chk_word(16, 16'hFFFF);
    for (int i = 0; i < 3; i++) `CHK(host.hold_w[i], 16'hFFF0)
    host.idle_clocks(3);
    `CHK(oe_b, 3'h7)
    host.finish();
  endtask

  task automatic t_abort();
    begin_frame(12, 1'b0);
    host.finish();
    `CHK({nm, oe_b}, 6'h3F)
    chk_word(12, 16'h0FFF);
  endtask

  task automatic t_noise();
    begin_frame(1, 1'b0);
    host.finish();
    `CHK({nm, oe_b}, 6'h3F)
  endtask

  task automatic t_fall_first();
    begin_frame(16, 1'b1);
    chk_word(16, 16'h7FFF);
    host.finish();
  endtask

  task automatic t_shut();
    begin_frame(5, 1'b0);
    host.finish();
    `CHK({nm, pw, oe_b}, 9'h007)
    begin_frame(5, 1'b0);
    host.finish();
    `CHK({nm, pw}, 6'h00)
    host.idle_clocks(4);
    `CHK({oe_b, hold}, 6'h38)
  endtask

  initial begin
    rst_b = 1'b0;
    valid = 1'b0;
    code  = '0;
    last  = '0;
    repeat (10) @(posedge clk);
    #DLY;
    rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #DLY;
    t_reset();
    t_fill();
    t_wake();
    t_full();
    t_abort();
    t_noise();
    t_fall_first();
    t_shut();
    t_wake();
    while (q.size() > 0) t_full();
    t_full();
    tally_and_finish();
  end

  // Run needs about 62 us; this cuts a hang short
  initial begin
    #400_000;
    bad_count++;
    tally_and_finish();
  end
endmodule // serial_sar_adc_interface_bench
